// >>> rtl/rec_top.sv
// Regulation enable control: strap address, role, programming mode, on/off
// decision, back-channel driver and soft-start PWM, with a Wishbone slave.
// Assumes pins and rail comparators arrive asynchronously to sys_clk.
//
// Register access over Wishbone and the placing of the registers were left to the implementer.
`timescale 1ns/1ns
module rec_top #(
    parameter int CLK_HZ = rec_pkg::CLK_HZ,
    parameter int SW_PERIOD = rec_pkg::SW_PERIOD_CYC,
    parameter int BC_HALF = rec_pkg::BC_HALF_CYC
) (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [rec_pkg::WB_AW-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [rec_pkg::WB_DW-1:0] wb_dat_i,
    output logic [rec_pkg::WB_DW-1:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [rec_pkg::STRAP_W-1:0] addressStrapPin,
    input wire logic enableLockoutPin,
    input wire logic analogRailOk,
    input wire logic internal5vRailOk,
    input wire logic internal5vConvOk,
    input wire logic powerStageInputOk,
    input wire logic internal5vAbove3v,
    input wire logic senseGroundAtBias,
    input wire logic [rec_pkg::MSEL_W-1:0] configSelectPin2,
    input wire logic backchannelClockIn,
    output logic backchannelClockOut,
    output logic backchannelClockOeN,
    input wire logic backchannelDataIn,
    output logic backchannelDataOut,
    output logic backchannelDataOeN,
    output logic [6:0] pmbusAddress,
    output logic pmbusTargetEnable,
    output logic highSideGate,
    output logic lowSideGate,
    output logic storeRequest,
    output logic [rec_pkg::MSEL_W-1:0] followerProg,
    output logic [rec_pkg::MSEL_W-1:0] standardProg
);
    import rec_pkg::*;

    // Bus target samples SCL/SDA on sys_clk; each speed needs enough samples per bit
    if (CLK_HZ < MIN_OVERSAMPLE * SMB_FASTPLUS_HZ) begin : g_bad_clk
        $error("sys_clk too slow for fast-plus bus timing");
    end
    if (SMB_STD_HZ > SMB_FAST_HZ || SMB_FAST_HZ > SMB_FASTPLUS_HZ) begin : g_bad_speeds
        $error("Bus speed table out of order");
    end
    if (BC_HALF < 1 || BC_HALF > 255) begin : g_bad_bc
        $error("BC_HALF must be 1 to 255");
    end

    localparam int SYNC_W = STRAP_W + MSEL_W + 9;
    localparam logic [7:0] BC_HALF_M1 = 8'(BC_HALF - 1);

    // Two-flop synchronisers for every pin and rail comparator
    logic [SYNC_W-1:0] syncA_r;
    logic [SYNC_W-1:0] syncB_r;
    wire [SYNC_W-1:0] rawPins = {addressStrapPin, configSelectPin2, enableLockoutPin,
        analogRailOk, internal5vRailOk, internal5vConvOk, powerStageInputOk,
        internal5vAbove3v, senseGroundAtBias, backchannelDataIn, backchannelClockIn};

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            syncA_r <= '0;
            syncB_r <= '0;
        end else begin
            syncA_r <= rawPins;
            syncB_r <= syncA_r;
        end
    end

    wire [STRAP_W-1:0] strapSync = syncB_r[SYNC_W-1 -: STRAP_W];
    wire [MSEL_W-1:0] mselSync = syncB_r[MSEL_W+8:9];
    wire enSync = syncB_r[8];
    wire analogOk = syncB_r[7];
    wire v5Ok = syncB_r[6];
    wire v5Conv = syncB_r[5];
    wire pvinOk = syncB_r[4];
    wire v5Above3 = syncB_r[3];
    wire senseGndSync = syncB_r[2];
    wire bcDatSync = syncB_r[1];
    wire bcClkSync = syncB_r[0];

    // Registers
    logic [7:0] operation_r;
    logic [7:0] onOffConfig_r;
    logic [7:0] onTime_r;
    logic [7:0] capStep_r;
    logic stackController_r;
    logic storeRefused_r;
    logic storeRequest_r;
    logic regEnable_r;
    logic ack_r;
    logic [WB_DW-1:0] datOut_r;

    // Power-on capture and role
    rec_por_t porState_r;
    logic [1:0] settle_r;
    logic [6:0] pmbusAddress_r;
    logic senseGndCap_r;
    logic [MSEL_W-1:0] followerProg_r;
    logic [MSEL_W-1:0] standardProg_r;
    logic targetEn_r;

    // Back-channel shifter
    rec_bc_t bcState_r;
    logic [7:0] bcDiv_r;
    logic bcClkLvl_r;
    logic [2:0] bcBit_r;
    logic [7:0] bcTx_r;
    logic [7:0] bcRx_r;

    rec_role_t role;
    rec_pwm_if pwmBus ();

    // Wishbone decode; ack comes one cycle after the request is seen
    wire wbReq = wb_cyc_i && wb_stb_i;
    wire wbWrite = wbReq && wb_we_i && ack_r;
    wire hitOper = wb_adr_i == ADDR_OPERATION;
    wire hitOnOff = wb_adr_i == ADDR_ON_OFF_CONFIG;
    wire hitStore = wb_adr_i == ADDR_STORE_ALL;
    wire hitCtrl = wb_adr_i == ADDR_CTRL;
    wire hitStatus = wb_adr_i == ADDR_STATUS;
    wire hitBc = wb_adr_i == ADDR_BACKCHAN;

    wire porDone = porState_r == POR_DONE;
    wire isFollower = senseGndCap_r && porDone;
    assign role = isFollower ? ROLE_FOLLOWER :
        (stackController_r ? ROLE_CONTROLLER : ROLE_STANDALONE);
    wire isController = role == ROLE_CONTROLLER;
    wire convReady = v5Conv && pvinOk;
    wire progMode = analogOk && v5Ok && !convReady;

    // On/off source selection; neither bit set means always on
    wire srcPin = onOffConfig_r[ONOFF_PIN_BIT] && !onOffConfig_r[ONOFF_CMD_BIT];
    wire srcCmd = onOffConfig_r[ONOFF_CMD_BIT] && !onOffConfig_r[ONOFF_PIN_BIT];
    wire srcBoth = onOffConfig_r[ONOFF_CMD_BIT] && onOffConfig_r[ONOFF_PIN_BIT];
    wire pinActive = onOffConfig_r[ONOFF_POL_BIT] ? enSync : !enSync;
    wire operOn = operation_r[OPER_ON_BIT];
    wire regEnNxt = srcPin ? pinActive :
        srcCmd ? operOn :
        srcBoth ? (pinActive && operOn) : 1'b1;

    wire [WB_DW-1:0] statusWord = {12'h000, bcClkSync, mselSync, convReady, storeRefused_r,
        bcState_r == BC_SHIFT, pwmBus.softDone, regEnable_r, progMode, role, pmbusAddress_r};
    wire [WB_DW-1:0] readData = hitOper ? {24'h000000, operation_r} :
        hitOnOff ? {24'h000000, onOffConfig_r} :
        hitCtrl ? {15'h0000, stackController_r, capStep_r, onTime_r} :
        hitStatus ? statusWord :
        hitBc ? {24'h000000, bcRx_r} : 32'h00000000;

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            ack_r <= 1'b0;
            datOut_r <= 32'h00000000;
        end else begin
            ack_r <= wbReq && !ack_r;
            if (wbReq && !ack_r) begin
                datOut_r <= readData;
            end
        end
    end

    assign wb_ack_o = ack_r;
    assign wb_dat_o = datOut_r;

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            operation_r <= OPERATION_RST;
            onOffConfig_r <= ON_OFF_CONFIG_RST;
            onTime_r <= ON_TIME_RST;
            capStep_r <= CAP_STEP_RST;
            stackController_r <= 1'b0;
        end else if (wbWrite) begin
            if (hitOper && wb_sel_i[0]) operation_r <= wb_dat_i[7:0];
            if (hitOnOff && wb_sel_i[0]) onOffConfig_r <= wb_dat_i[7:0];
            if (hitCtrl && wb_sel_i[0]) onTime_r <= wb_dat_i[7:0];
            if (hitCtrl && wb_sel_i[1]) capStep_r <= wb_dat_i[15:8];
            if (hitCtrl && wb_sel_i[2]) stackController_r <= wb_dat_i[CTRL_STACK_BIT];
        end
    end

    // Store under 3 V would corrupt NVM, so it is refused and flagged; set beats clear
    wire storeHit = wbWrite && hitStore && wb_sel_i[0];
    wire refuseEvt = storeHit && !v5Above3;
    wire refuseClr = wbWrite && hitStatus && wb_sel_i[1] && wb_dat_i[ST_REFUSED_BIT];

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            storeRequest_r <= 1'b0;
            storeRefused_r <= 1'b0;
            regEnable_r <= 1'b0;
        end else begin
            storeRequest_r <= storeHit && v5Above3;
            storeRefused_r <= refuseEvt || (storeRefused_r && !refuseClr);
            regEnable_r <= regEnNxt;
        end
    end

    // Straps caught after reset release once low rails are up; no power stage needed
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            porState_r <= POR_WAIT;
            settle_r <= 2'h0;
            pmbusAddress_r <= ADDR_LOW;
            senseGndCap_r <= 1'b0;
            followerProg_r <= '0;
            standardProg_r <= '0;
        end else if (porState_r == POR_WAIT) begin
            if (settle_r != STRAP_SETTLE_CYC) begin
                settle_r <= settle_r + 2'h1;
            end else if (analogOk && v5Ok) begin
                porState_r <= POR_DONE;
                pmbusAddress_r <= ADDR_LOW + {2'b00, strapSync};
                senseGndCap_r <= senseGndSync;
                if (senseGndSync) begin
                    followerProg_r <= mselSync;
                end else begin
                    standardProg_r <= mselSync;
                end
            end
        end
    end

    // Bus target alive in programming mode too; followers keep bus pins grounded
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            targetEn_r <= 1'b0;
        end else begin
            targetEn_r <= analogOk && v5Ok && porDone && !senseGndCap_r;
        end
    end

    // Back-channel: controller shifts one byte MSB first, sampling on rising edge
    wire bcTick = bcDiv_r == BC_HALF_M1;
    wire bcStart = wbWrite && hitBc && wb_sel_i[0] && isController && bcState_r == BC_IDLE;

    always_ff @(posedge sys_clk) begin
        if (srst || bcState_r == BC_IDLE || bcTick) begin
            bcDiv_r <= 8'h00;
        end else begin
            bcDiv_r <= bcDiv_r + 8'h01;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            bcState_r <= BC_IDLE;
            bcClkLvl_r <= 1'b0;
            bcBit_r <= 3'h0;
            bcTx_r <= 8'h00;
            bcRx_r <= 8'h00;
        end else begin
            unique case (bcState_r)
                BC_IDLE: begin
                    if (bcStart) begin
                        bcState_r <= BC_SHIFT;
                        bcTx_r <= wb_dat_i[7:0];
                        bcBit_r <= 3'h0;
                    end
                end
                BC_SHIFT: begin
                    if (!isController) begin
                        bcState_r <= BC_IDLE;
                        bcClkLvl_r <= 1'b0;
                    end else if (bcTick && !bcClkLvl_r) begin
                        bcClkLvl_r <= 1'b1;
                        bcRx_r <= {bcRx_r[6:0], bcDatSync};
                    end else if (bcTick) begin
                        bcClkLvl_r <= 1'b0;
                        bcTx_r <= {bcTx_r[6:0], 1'b0};
                        bcBit_r <= bcBit_r + 3'h1;
                        if (bcBit_r == 3'h7) bcState_r <= BC_IDLE;
                    end
                end
            endcase
        end
    end

    // Only a controller drives; standalone and follower leave the lines released
    assign backchannelClockOut = bcClkLvl_r;
    assign backchannelDataOut = bcTx_r[7];
    assign backchannelClockOeN = !isController;
    assign backchannelDataOeN = !isController;

    // Switching needs conversion rails; programming mode holds it off
    assign pwmBus.run = regEnable_r && convReady && porDone && !progMode;
    assign pwmBus.onTime = onTime_r;
    assign pwmBus.capStep = capStep_r;

    rec_pwm_gen #(.PERIOD_CYC(SW_PERIOD)) u_pwm (
        .sys_clk(sys_clk),
        .srst(srst),
        .pwm(pwmBus.gen)
    );

    assign highSideGate = pwmBus.hsGate;
    assign lowSideGate = pwmBus.lsGate;
    assign storeRequest = storeRequest_r;
    assign pmbusAddress = pmbusAddress_r;
    assign pmbusTargetEnable = targetEn_r;
    assign followerProg = followerProg_r;
    assign standardProg = standardProg_r;

    // Helper age counter so the on/off control checks skip the first cycles after reset
    logic [1:0] age_r;
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            age_r <= 2'h0;
        end else if (age_r != 2'h3) begin
            age_r <= age_r + 2'h1;
        end
    end
    wire aged = age_r == 2'h3;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);

    sequence seqCaptured;
        porState_r == POR_WAIT ##1 porState_r == POR_DONE;
    endsequence

    chk_addr_range: assert property (
        seqCaptured |-> pmbusAddress_r >= ADDR_LOW && pmbusAddress_r <= ADDR_HIGH
            && pmbusAddress_r == ADDR_LOW + {2'b00, $past(strapSync)})
        else $error("Strap address wrong");
    chk_prog_no_switch: assert property (
        progMode |-> !highSideGate && !lowSideGate)
        else $error("Switching in programming mode");
    chk_follower_role: assert property (
        seqCaptured ##0 $past(senseGndSync) |-> role == ROLE_FOLLOWER
            && followerProg_r == $past(mselSync))
        else $error("Follower role or setup wrong");
    chk_standalone_quiet: assert property (
        !stackController_r || senseGndCap_r |-> backchannelClockOeN && backchannelDataOeN)
        else $error("Non-controller drives back-channel");
    chk_pin_control: assert property (
        aged && $past(srcPin) |-> regEnable_r ==
            ($past(onOffConfig_r[ONOFF_POL_BIT]) ? $past(enableLockoutPin, 3)
                                                 : !$past(enableLockoutPin, 3)))
        else $error("Pin control enable wrong");
    chk_cmd_control: assert property (
        aged && $past(srcCmd) |-> regEnable_r == $past(operOn))
        else $error("Command control enable wrong");
    chk_both_control: assert property (
        aged && $past(srcBoth) |-> regEnable_r == $past(operOn && pinActive))
        else $error("Combined control enable wrong");
    chk_store_guard: assert property (
        storeHit && !v5Above3 |=> !storeRequest_r && storeRefused_r)
        else $error("Store accepted under 3 V");
endmodule // rec_top

// >>> common/rec_pkg.sv
// Constants, register map and types of the regulation enable control block.
// Assumes a 10 MHz sys_clk and a classic Wishbone master with 32-bit data.
package rec_pkg;
    localparam int WB_AW = 10;
    localparam int WB_DW = 32;

    // Printed command codes are register indices; byte address is four times that
    localparam logic [7:0] IDX_OPERATION = 8'h01;
    localparam logic [7:0] IDX_ON_OFF_CONFIG = 8'h02;
    localparam logic [7:0] IDX_STORE_ALL = 8'h15;
    localparam logic [7:0] IDX_CTRL = 8'h40;
    localparam logic [7:0] IDX_STATUS = 8'h41;
    localparam logic [7:0] IDX_BACKCHAN = 8'h42;
    localparam logic [WB_AW-1:0] ADDR_OPERATION = {IDX_OPERATION, 2'b00};
    localparam logic [WB_AW-1:0] ADDR_ON_OFF_CONFIG = {IDX_ON_OFF_CONFIG, 2'b00};
    localparam logic [WB_AW-1:0] ADDR_STORE_ALL = {IDX_STORE_ALL, 2'b00};
    localparam logic [WB_AW-1:0] ADDR_CTRL = {IDX_CTRL, 2'b00};
    localparam logic [WB_AW-1:0] ADDR_STATUS = {IDX_STATUS, 2'b00};
    localparam logic [WB_AW-1:0] ADDR_BACKCHAN = {IDX_BACKCHAN, 2'b00};

    localparam logic [7:0] OPERATION_RST = 8'h04;
    localparam logic [7:0] ON_OFF_CONFIG_RST = 8'h17;
    localparam logic [7:0] ON_TIME_RST = 8'h08;
    localparam logic [7:0] CAP_STEP_RST = 8'h01;
    localparam int OPER_ON_BIT = 7;
    localparam int ONOFF_CMD_BIT = 3;
    localparam int ONOFF_PIN_BIT = 2;
    localparam int ONOFF_POL_BIT = 1;
    localparam int CTRL_STACK_BIT = 16;

    localparam int ST_ROLE_LSB = 7;
    localparam int ST_PROG_BIT = 9;
    localparam int ST_REGEN_BIT = 10;
    localparam int ST_SOFTDONE_BIT = 11;
    localparam int ST_BCBUSY_BIT = 12;
    localparam int ST_REFUSED_BIT = 13;
    localparam int ST_CONV_BIT = 14;
    localparam int ST_MSEL_LSB = 15;
    localparam int ST_BCCLK_BIT = 19;

    localparam logic [6:0] ADDR_LOW = 7'h10;
    localparam logic [6:0] ADDR_HIGH = 7'h2F;
    localparam int STRAP_W = 5;
    localparam int MSEL_W = 4;

    localparam int CLK_HZ = 10_000_000;
    localparam int CLK_PERIOD_NS = 100;
    localparam int SMB_STD_HZ = 100_000;
    localparam int SMB_FAST_HZ = 400_000;
    localparam int SMB_FASTPLUS_HZ = 1_000_000;
    localparam int MIN_OVERSAMPLE = 8;
    localparam logic [1:0] STRAP_SETTLE_CYC = 2'h3;
    localparam int SW_PERIOD_NS = 2000;
    localparam int SW_PERIOD_CYC = SW_PERIOD_NS / CLK_PERIOD_NS;
    localparam int BC_PERIOD_NS = 1000;
    localparam int BC_HALF_CYC = (BC_PERIOD_NS / 2) / CLK_PERIOD_NS;

    typedef enum logic [1:0] {ROLE_STANDALONE, ROLE_CONTROLLER, ROLE_FOLLOWER} rec_role_t;
    typedef enum logic {POR_WAIT, POR_DONE} rec_por_t;
    typedef enum logic {BC_IDLE, BC_SHIFT} rec_bc_t;
endpackage

// >>> common/rec_pwm_if.sv
// Carrier between the enable logic and the PWM soft-start generator.
// Assumes both ends sit on sys_clk.
`timescale 1ns/1ns
interface rec_pwm_if;
    logic run;
    logic [7:0] onTime;
    logic [7:0] capStep;
    logic hsGate;
    logic lsGate;
    logic pulseStart;
    logic softDone;
    modport ctrl (output run, output onTime, output capStep,
                  input hsGate, input lsGate, input pulseStart, input softDone);
    modport gen (input run, input onTime, input capStep,
                 output hsGate, output lsGate, output pulseStart, output softDone);
endinterface // rec_pwm_if

// >>> rtl/rec_pwm_gen.sv
// Fixed-frequency PWM with low-side on-time ramp during soft start.
// Assumes run drops whenever regulation stops, which restarts the ramp.
`timescale 1ns/1ns
module rec_pwm_gen #(
    parameter int PERIOD_CYC = rec_pkg::SW_PERIOD_CYC
) (
    input wire logic sys_clk,
    input wire logic srst,
    rec_pwm_if.gen pwm
);
    import rec_pkg::*;

    // 256 would wrap the 8-bit period constant to zero
    if (PERIOD_CYC < 2 || PERIOD_CYC > 255) begin : g_bad_period
        $error("PERIOD_CYC must be 2 to 255");
    end

    localparam logic [7:0] PERIOD8 = 8'(PERIOD_CYC);
    localparam logic [7:0] PERIOD_M1 = 8'(PERIOD_CYC - 1);

    logic [7:0] phase_r;
    logic [7:0] lsCap_r;
    logic pulsed_r;
    logic softDone_r;
    logic [7:0] lsCount_r;

    wire lastPhase = phase_r == PERIOD_M1;
    wire [7:0] onClamp = (pwm.onTime > PERIOD_M1) ? PERIOD_M1 : pwm.onTime;
    wire [7:0] room = PERIOD8 - onClamp;
    wire [7:0] lsOff = phase_r - onClamp;
    wire [8:0] capSum = {1'b0, lsCap_r} + {1'b0, pwm.capStep};

    // Phase counter never stops, so the frequency does not follow load
    always_ff @(posedge sys_clk) begin
        if (srst || lastPhase) begin
            phase_r <= 8'h00;
        end else begin
            phase_r <= phase_r + 8'h01;
        end
    end

    assign pwm.hsGate = pwm.run && (phase_r < onClamp);
    assign pwm.lsGate = pwm.run && (phase_r >= onClamp) && (softDone_r || lsOff < lsCap_r);
    assign pwm.pulseStart = pwm.run && (phase_r == 8'h00) && (onClamp != 8'h00);
    assign pwm.softDone = softDone_r;

    // Cap starts at zero to avoid sinking a prebiased output; step of zero never completes
    always_ff @(posedge sys_clk) begin
        if (srst || !pwm.run) begin
            lsCap_r <= 8'h00;
            pulsed_r <= 1'b0;
            softDone_r <= 1'b0;
        end else if (pwm.pulseStart) begin
            pulsed_r <= 1'b1;
            if (pulsed_r && !softDone_r) begin
                if (capSum >= {1'b0, room}) begin
                    lsCap_r <= room;
                    softDone_r <= 1'b1;
                end else begin
                    lsCap_r <= capSum[7:0];
                end
            end
        end
    end

    // Low-side cycles so far this period, counted apart from the gate logic
    always_ff @(posedge sys_clk) begin
        if (srst || lastPhase) begin
            lsCount_r <= 8'h00;
        end else if (pwm.lsGate) begin
            lsCount_r <= lsCount_r + 8'h01;
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);

    sequence seqRampPulse;
        pwm.pulseStart && pulsed_r && !softDone_r;
    endsequence

    chk_fixed_period: assert property (
        (phase_r == 8'h00) && !$past(srst) |-> $past(phase_r) == PERIOD_M1)
        else $error("PWM period broken");
    chk_gates_exclusive: assert property (
        !(pwm.hsGate && pwm.lsGate))
        else $error("High and low side on together");
    chk_ls_capped: assert property (
        pwm.lsGate && !softDone_r |-> lsCount_r < lsCap_r)
        else $error("Low-side on-time exceeds cap");
    chk_cap_rises: assert property (
        seqRampPulse ##0 (capSum < {1'b0, room}) ##1 pwm.run
            |-> lsCap_r == $past(capSum[7:0]))
        else $error("Low-side cap not raised on pulse");
endmodule // rec_pwm_gen

// >>> dv/rec_wb_host.sv
// Wishbone host model standing in for the system management host.
// Assumes a slave that answers each request with a one-cycle ack.
`timescale 1ns/1ns
module rec_wb_host (
    input wire logic sys_clk,
    output logic wb_cyc_i,
    output logic wb_stb_i,
    output logic wb_we_i,
    output logic [9:0] wb_adr_i,
    output logic [3:0] wb_sel_i,
    output logic [31:0] wb_dat_i,
    input wire logic wb_ack_o,
    input wire logic [31:0] wb_dat_o
);
    initial {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = '0;
    // Request held until ack is sampled; the next call leaves one idle cycle
    task automatic xfer(input logic w, input logic [9:0] a, input logic [31:0] d,
                        output logic [31:0] q);
        @(posedge sys_clk);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} <= {2'b11, w, a, 4'hF, d};
        do @(posedge sys_clk); while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        {wb_cyc_i, wb_stb_i} <= 2'b00;
    endtask
endmodule // rec_wb_host

// >>> dv/tb_top.sv
// Self-checking bench: straps, modes, on/off control, PWM and back channel.
// Assumes rec_wb_host drives the register bus on a 10 MHz sys_clk.
`timescale 1ns/1ns
module tb_top;
    import rec_pkg::*;
    logic sys_clk, srst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, pin, railOk, convOk, op;
    logic powerStageInputOk, above3v, atBias, bcClk, bcClkN, bcDat, bcDatN;
    logic pmbusTargetEnable, highSideGate, lowSideGate, storeRequest, e;
    logic [9:0] wb_adr_i;
    logic [3:0] wb_sel_i, msel, followerProg, standardProg;
    logic [31:0] wb_dat_i, wb_dat_o, q;
    logic [4:0] strap;
    logic [6:0] pmbusAddress;
    logic [7:0] b;
    logic [7:0] cfgs [6] = '{8'h14, 8'h16, 8'h18, 8'h1C, 8'h1E, 8'h10};
    int errCount = 0, nChecks = 0, seed = 3516, nStore = 0, cnt, bad;
    rec_wb_host host_u (.sys_clk, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
        .wb_dat_i, .wb_ack_o, .wb_dat_o);
    rec_top dut_u (.sys_clk, .srst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
        .wb_dat_i, .wb_dat_o, .wb_ack_o, .addressStrapPin(strap), .enableLockoutPin(pin),
        .analogRailOk(railOk), .internal5vRailOk(railOk), .internal5vConvOk(convOk),
        .powerStageInputOk, .internal5vAbove3v(above3v), .senseGroundAtBias(atBias),
        .configSelectPin2(msel), .backchannelClockIn(bcClkN ? 1'b0 : bcClk),
        .backchannelClockOut(bcClk), .backchannelClockOeN(bcClkN),
        .backchannelDataIn(bcDatN ? 1'b0 : bcDat), .backchannelDataOut(bcDat),
        .backchannelDataOeN(bcDatN), .pmbusAddress, .pmbusTargetEnable, .highSideGate,
        .lowSideGate, .storeRequest, .followerProg, .standardProg);
    task automatic check(input string what, input logic [31:0] seen, exp);
        nChecks++;
        if (seen !== exp) begin
            errCount++;
            $display("Error %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [9:0] a, input logic [31:0] d);
        host_u.xfer(1'b1, a, d, q);
    endtask
    task automatic boot;
        srst <= 1'b1;
        repeat (6) @(posedge sys_clk);
        srst <= 1'b0;
        repeat (12) @(posedge sys_clk);
    endtask
    task automatic giveVerdict;
        $display("Checks %0d errors %0d", nChecks, errCount);
        if (errCount == 0 && nChecks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    function automatic logic expEn(input logic [7:0] cfg, input logic p, input logic o);
        logic pv;
        pv = (p == cfg[ONOFF_POL_BIT]);
        case (cfg[3:2])
            2'b01: return pv;
            2'b10: return o;
            2'b11: return pv & o;
            default: return 1'b1;
        endcase
    endfunction
    always @(posedge sys_clk) if (storeRequest === 1'b1) nStore++;
    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end
    initial begin
        repeat (20000) @(posedge sys_clk);
        errCount++;
        giveVerdict();
    end
    initial begin
        {srst, pin, railOk, convOk, powerStageInputOk, above3v, atBias} = 7'b1011000;
        {strap, msel} = 9'($random(seed));
        boot();
        check("address", pmbusAddress, ADDR_LOW + strap);
        check("stdProg", standardProg, msel);
        check("idleOeN", {bcClkN, bcDatN}, 2'b11);
        host_u.xfer(1'b0, ADDR_STATUS, '0, q);
        check("progMode", {q[ST_PROG_BIT], pmbusTargetEnable, highSideGate, lowSideGate}, 4'hC);
        wr(ADDR_STORE_ALL, 32'h1);
        host_u.xfer(1'b0, ADDR_STATUS, '0, q);
        check("refused", {q[ST_REFUSED_BIT], 5'(nStore)}, 6'h20);
        wr(ADDR_STATUS, 32'h1 << ST_REFUSED_BIT);
        host_u.xfer(1'b0, ADDR_STATUS, '0, q);
        check("refusedClr", q[ST_REFUSED_BIT], 1'b0);
        above3v <= 1'b1;
        powerStageInputOk <= 1'b1;
        wr(ADDR_STORE_ALL, 32'h1);
        repeat (2) @(posedge sys_clk);
        check("store", nStore, 1);
        foreach (cfgs[i]) begin
            repeat (4) begin
                op = 1'($random(seed));
                @(posedge sys_clk);
                pin <= 1'($random(seed));
                wr(ADDR_ON_OFF_CONFIG, {24'h0, cfgs[i]});
                wr(ADDR_OPERATION, {24'h0, op, 7'h04});
                repeat (5) @(posedge sys_clk);
                e = expEn(cfgs[i], pin, op);
                host_u.xfer(1'b0, ADDR_STATUS, '0, q);
                check("regEn", q[ST_REGEN_BIT], e);
            end
        end
        wr(ADDR_ON_OFF_CONFIG, 32'h18);
        wr(ADDR_OPERATION, 32'h04);
        wr(ADDR_OPERATION, 32'h84);
        cnt = 0;
        repeat (SW_PERIOD_CYC) @(posedge sys_clk) cnt += lowSideGate;
        check("lsCap", cnt < 4, 1);
        repeat (400) @(posedge sys_clk);
        {cnt, bad} = '0;
        repeat (SW_PERIOD_CYC) begin
            @(posedge sys_clk);
            cnt += highSideGate;
            bad += (lowSideGate !== ~highSideGate);
        end
        check("onTime", cnt, ON_TIME_RST);
        check("complement", bad, 0);
        wr(ADDR_CTRL, 32'h0001_0108);
        @(posedge sys_clk);
        check("ctrlOeN", {bcClkN, bcDatN}, 2'b00);
        b = 8'($random(seed));
        wr(ADDR_BACKCHAN, {24'h0, b});
        cnt = 0;
        repeat (120) @(posedge sys_clk) cnt += bcClk;
        check("bcHigh", cnt, 8 * BC_HALF_CYC);
        host_u.xfer(1'b0, ADDR_BACKCHAN, '0, q);
        check("bcLoop", q[7:0], b);
        atBias <= 1'b1;
        boot();
        check("follower", {followerProg, standardProg}, {msel, 4'h0});
        check("followerPins", {bcClkN, bcDatN, pmbusTargetEnable}, 3'b110);
        giveVerdict();
    end
endmodule // tb_top
